//--- pkg/pmx_cfg.svh
// Constants for the port 0 duplex, management pin and indicator five pin mux
// Summary of operation
// [RULE1] MAC mode: duplex pin live, autoneg overrides
// [RULE2] PHY modes: duplex pin forms partner ability
// [RULE3] Data line to slave or master engine
// [RULE4] Slave modes: outside master drives management clock
// [RULE5] Master modes: device drives management clock
// [RULE6] Straps captured at power-on and reset release
// [RULE7] EEPROM loader may replace latched straps
// [RULE8] LED enable set: pin is indicator
// [RULE9] LED enable clear: pin is general IO
// [RULE10] LED function field picks driver type
// [RULE11] Open LED polarity from address strap
// [RULE12] Address strap sets default management addresses
// [RULE13] Captured straps hold until next capture
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

// Register bus geometry
`define PMX_ADDR_W          8
`define PMX_DATA_W          32

// Register offsets (byte addresses)
`define PMX_REG_LED_CONFIGURATION     8'h00
`define PMX_REG_GPIO_CFG    8'h04
`define PMX_REG_GPIO_DDR    8'h08
`define PMX_REG_VPORT_CTRL  8'h0c
`define PMX_REG_MODE        8'h10
`define PMX_REG_STRAP_STAT  8'h14
`define PMX_REG_ADDR_STAT   8'h18

// Field positions
`define PMX_INDICATOR_FIVE_EN_BIT     0
`define PMX_LED_FUN_LSB     8
`define PMX_LED_FUN_MSB     9
`define PMX_GPIO_OD_BIT     0
`define PMX_GPIO_DATA_BIT   0
`define PMX_GPIO_DIR_BIT    8
`define PMX_GPIO_PIN_BIT    16
`define PMX_VPORT_AN_BIT    12
`define PMX_MODE_LSB        0
`define PMX_MODE_MSB        1
`define PMX_MGMT_MASTER_BIT 4
`define PMX_ST_ADDR_BIT     0
`define PMX_ST_DPOL_BIT     1
`define PMX_ST_DPIN_BIT     8
`define PMX_ST_DEFF_BIT     9
`define PMX_AD_VPHY_LSB     0
`define PMX_AD_P1_LSB       8
`define PMX_AD_P2_LSB       16

// Field encodings and reset values
`define PMX_LED_FUN_PUSH    2'h0
`define PMX_LED_FUN_RST     2'h0
`define PMX_MODE_RST        2'h0
`define PMX_STRAP_RST       2'h0
`define PMX_ABIL_FULL       2'h2
`define PMX_ABIL_HALF       2'h1

// Default management addresses per strap level
`define PMX_VPHY_ADDR_S0    5'h00
`define PMX_P1_ADDR_S0      5'h01
`define PMX_P2_ADDR_S0      5'h02
`define PMX_VPHY_ADDR_S1    5'h01
`define PMX_P1_ADDR_S1      5'h02
`define PMX_P2_ADDR_S1      5'h03

`endif

//--- pkg/pmx_pkg.sv
// Types shared by the pin mux design files
package pmx_pkg;

  // Port 0 operating mode
  typedef enum logic [1:0] {
    PMX_P0_MAC,
    PMX_P0_MII_PHY,
    PMX_P0_RMII_PHY,
    PMX_P0_RSVD
  } pmx_p0_mode_t;

  // Straps that are latched at reset release
  typedef struct packed {
    logic port0_duplex_polarity_strap;
    logic address_and_led_polarity_strap;
  } pmx_straps_t;

  // EEPROM loader override request
  typedef struct packed {
    logic        valid;
    pmx_straps_t mask;
    pmx_straps_t value;
  } pmx_strap_ovr_t;

  // One two-signal pin driver (output and enable) as seen from the design
  typedef struct packed {
    logic o;
    logic oe;
  } pmx_pin_drv_t;

  // Default management addresses
  typedef struct packed {
    logic [4:0] vphy;
    logic [4:0] port1;
    logic [4:0] port2;
  } pmx_mgmt_addr_t;

endpackage : pmx_pkg

//--- logic/pmx_strap_latch.sv
// Strap capture and hold with EEPROM override
`timescale 1ns/10ps
`include "pmx_cfg.svh"

module pmx_strap_latch (
  input  wire logic                    ref_clk_in,
  input  wire logic                    resetn_in,
  input  wire logic                    capture_in,
  input  wire pmx_pkg::pmx_straps_t    strap_in,
  input  wire pmx_pkg::pmx_strap_ovr_t ovr_in,
  output logic [1:0]                   value_out
);
  import pmx_pkg::*;

  logic [1:0] strap_bits;
  logic [1:0] ovr_mask;
  logic [1:0] ovr_val;

  // Flatten the structs so the loop can index by bit
  assign strap_bits = strap_in;
  assign ovr_mask   = ovr_in.mask;
  assign ovr_val    = ovr_in.value;

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      // Override wins over capture in a shared cycle
      always_ff @(posedge ref_clk_in) begin
        if (!resetn_in) begin
          value_out[i] <= 1'b0;
        // [RULE7] EEPROM override
        end else if (ovr_in.valid && ovr_mask[i]) begin
          value_out[i] <= ovr_val[i];
        // [RULE6] capture strap level
        end else if (capture_in) begin
          value_out[i] <= strap_bits[i];
        end
        // [RULE13] hold otherwise
      end
    end
  endgenerate

endmodule : pmx_strap_latch

//--- logic/pmx_pin_mux.sv
// Port 0 duplex, management and indicator five pin mux with straps
`timescale 1ns/10ps
`include "pmx_cfg.svh"

module pmx_pin_mux (
  input  wire logic                       ref_clk_in,
  input  wire logic                       resetn_in,
  // External reset pin, synchronous to the clock
  input  wire logic                       external_reset_n_in,
  // Register port
  input  wire logic [`PMX_ADDR_W-1:0]     reg_addr_in,
  input  wire logic [`PMX_DATA_W-1:0]     reg_wdata_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  output logic [`PMX_DATA_W-1:0]          reg_rdata_out,
  // Strap pin levels and EEPROM loader
  input  wire pmx_pkg::pmx_straps_t       strap_pins_in,
  input  wire pmx_pkg::pmx_strap_ovr_t    eeprom_ovr_in,
  // Port 0 duplex
  input  wire logic                       port0_duplex_in,
  input  wire logic                       vport_an_duplex_in,
  output logic                            port0_duplex_eff_out,
  output logic [1:0]                      vport_partner_ability_out,
  // Management data pin
  input  wire logic                       mdio_pin_in,
  output logic                            mdio_pin_out,
  output logic                            mdio_pin_oe_out,
  // Management clock pin
  input  wire logic                       mdc_pin_in,
  output logic                            mdc_pin_out,
  output logic                            mdc_pin_oe_out,
  // Slave management engine
  input  wire pmx_pkg::pmx_pin_drv_t      slave_mdio_drv_in,
  output logic                            slave_mdio_rx_out,
  output logic                            slave_mdc_out,
  // Master management engine
  input  wire pmx_pkg::pmx_pin_drv_t      master_mdio_drv_in,
  input  wire logic                       master_mdc_in,
  output logic                            master_mdio_rx_out,
  // Indicator five / general IO five pin
  input  wire logic                       indicator_five_on_in,
  input  wire logic                       general_io_five_pin_in,
  output logic                            general_io_five_pin_out,
  output logic                            general_io_five_pin_oe_out,
  output logic                            general_io_five_level_out,
  // Default management addresses
  output pmx_pkg::pmx_mgmt_addr_t         mgmt_addr_out
);
  import pmx_pkg::*;

  // Software controlled state
  logic                 indicator_five_enable_q;
  logic [1:0]           led_driver_function_q;
  logic                 gpio_open_drain_q;
  logic                 gpio_data_q;
  logic                 gpio_dir_out_q;
  logic                 vport_autoneg_enable_q;
  pmx_p0_mode_t         p0_mode_q;
  logic                 mgmt_master_q;

  // Strap capture state
  logic                 por_done_q;
  logic                 ext_rst_n_q;
  logic                 capture_d;
  logic [1:0]           strap_val;
  pmx_straps_t          straps;

  // Derived combinational values
  logic                 duplex_pin_val;
  logic                 duplex_eff_d;
  logic [1:0]           ability_d;
  pmx_mgmt_addr_t       addr_d;
  logic                 led_open;
  logic                 led_on_level;
  pmx_pin_drv_t         led_drv_d;
  pmx_pin_drv_t         gpio_drv_d;
  pmx_pin_drv_t         io5_drv_d;
  pmx_pin_drv_t         mdio_drv_d;
  pmx_pin_drv_t         mdc_drv_d;
  logic [`PMX_DATA_W-1:0] rdata_d;

  // Capture on the first edge after reset and on external release.
  // Reset itself never samples the strap pins.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= 1'b1;
    end
  end

  // Last external reset level, for release edge
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      ext_rst_n_q <= 1'b0;
    end else begin
      ext_rst_n_q <= external_reset_n_in;
    end
  end

  // [RULE6] power-on and release capture
  assign capture_d = !por_done_q || (external_reset_n_in && !ext_rst_n_q);

  // Strap values held until next capture or override
  pmx_strap_latch u_strap_latch (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .capture_in (capture_d),
    .strap_in   (strap_pins_in),
    .ovr_in     (eeprom_ovr_in),
    .value_out  (strap_val)
  );

  assign straps = pmx_straps_t'(strap_val);

  // LED configuration register
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      indicator_five_enable_q         <= 1'b0;
      led_driver_function_q <= `PMX_LED_FUN_RST;
    end else if (reg_wr_in && reg_addr_in == `PMX_REG_LED_CONFIGURATION) begin
      indicator_five_enable_q         <= reg_wdata_in[`PMX_INDICATOR_FIVE_EN_BIT];
      led_driver_function_q <= reg_wdata_in[`PMX_LED_FUN_MSB:`PMX_LED_FUN_LSB];
    end
  end

  // General IO configuration register
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      gpio_open_drain_q <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `PMX_REG_GPIO_CFG) begin
      gpio_open_drain_q <= reg_wdata_in[`PMX_GPIO_OD_BIT];
    end
  end

  // General IO data and direction; input after reset
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      gpio_data_q    <= 1'b0;
      gpio_dir_out_q <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `PMX_REG_GPIO_DDR) begin
      gpio_data_q    <= reg_wdata_in[`PMX_GPIO_DATA_BIT];
      gpio_dir_out_q <= reg_wdata_in[`PMX_GPIO_DIR_BIT];
    end
  end

  // Virtual port basic control register
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      vport_autoneg_enable_q <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `PMX_REG_VPORT_CTRL) begin
      vport_autoneg_enable_q <= reg_wdata_in[`PMX_VPORT_AN_BIT];
    end
  end

  // Port 0 mode and management direction
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      p0_mode_q     <= pmx_p0_mode_t'(`PMX_MODE_RST);
      mgmt_master_q <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `PMX_REG_MODE) begin
      p0_mode_q     <= pmx_p0_mode_t'(reg_wdata_in[`PMX_MODE_MSB:`PMX_MODE_LSB]);
      mgmt_master_q <= reg_wdata_in[`PMX_MGMT_MASTER_BIT];
    end
  end

  // Duplex pin after polarity strap
  assign duplex_pin_val = port0_duplex_in ^ straps.port0_duplex_polarity_strap;

  // Duplex and partner ability per mode
  always_comb begin
    duplex_eff_d = duplex_pin_val;
    ability_d    = duplex_pin_val ? `PMX_ABIL_FULL : `PMX_ABIL_HALF;
    case (p0_mode_q)
      PMX_P0_MAC: begin
        // [RULE1] live pin, autoneg overrides
        duplex_eff_d = vport_autoneg_enable_q ? vport_an_duplex_in : duplex_pin_val;
      end
      PMX_P0_MII_PHY,
      PMX_P0_RMII_PHY: begin
        // [RULE2] pin forms partner ability
        ability_d = duplex_pin_val ? `PMX_ABIL_FULL : `PMX_ABIL_HALF;
      end
      default: begin
        duplex_eff_d = duplex_pin_val;
      end
    endcase
  end

  // Duplex outputs, updated every cycle as the pin is live
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      port0_duplex_eff_out      <= 1'b0;
      vport_partner_ability_out <= `PMX_ABIL_HALF;
    end else begin
      port0_duplex_eff_out      <= duplex_eff_d;
      vport_partner_ability_out <= ability_d;
    end
  end

  // Management data and clock routing
  always_comb begin
    if (mgmt_master_q) begin
      // [RULE3] data toward external PHY
      mdio_drv_d = master_mdio_drv_in;
      // [RULE5] device drives clock
      mdc_drv_d  = '{o: master_mdc_in, oe: 1'b1};
    end else begin
      // [RULE3] data toward outside master
      mdio_drv_d = slave_mdio_drv_in;
      // [RULE4] clock input only
      mdc_drv_d  = '{o: 1'b0, oe: 1'b0};
    end
  end

  // Management pins; one stage keeps outputs flop-driven
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      mdio_pin_out    <= 1'b0;
      mdio_pin_oe_out <= 1'b0;
      mdc_pin_out     <= 1'b0;
      mdc_pin_oe_out  <= 1'b0;
    end else begin
      mdio_pin_out    <= mdio_drv_d.o;
      mdio_pin_oe_out <= mdio_drv_d.oe;
      mdc_pin_out     <= mdc_drv_d.o;
      mdc_pin_oe_out  <= mdc_drv_d.oe;
    end
  end

  // Received levels go only to the owning engine;
  // the idle engine sees data held at one and the slave clock at zero
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      slave_mdio_rx_out  <= 1'b1;
      master_mdio_rx_out <= 1'b1;
      slave_mdc_out      <= 1'b0;
    end else begin
      slave_mdio_rx_out  <= mgmt_master_q ? 1'b1 : mdio_pin_in;
      master_mdio_rx_out <= mgmt_master_q ? mdio_pin_in : 1'b1;
      slave_mdc_out      <= mgmt_master_q ? 1'b0 : mdc_pin_in;
    end
  end

  // [RULE11] open LED polarity from strap
  assign led_open     = (led_driver_function_q != `PMX_LED_FUN_PUSH);
  assign led_on_level = ~straps.address_and_led_polarity_strap;

  // Indicator: push-pull always drives, open drives on level
  always_comb begin
    // [RULE10] function field picks driver
    if (!led_open) begin
      led_drv_d = '{o: indicator_five_on_in, oe: 1'b1};
    end else begin
      led_drv_d = '{o: led_on_level, oe: indicator_five_on_in};
    end
  end

  // General IO driver: push-pull, open-drain or input
  always_comb begin
    // [RULE9] general IO modes
    if (!gpio_dir_out_q) begin
      gpio_drv_d = '{o: 1'b0, oe: 1'b0};
    end else if (gpio_open_drain_q) begin
      gpio_drv_d = '{o: 1'b0, oe: ~gpio_data_q};
    end else begin
      gpio_drv_d = '{o: gpio_data_q, oe: 1'b1};
    end
  end

  // [RULE8] enable bit selects indicator
  assign io5_drv_d = indicator_five_enable_q ? led_drv_d : gpio_drv_d;

  // Shared pin registers, released in reset
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      general_io_five_pin_out    <= 1'b0;
      general_io_five_pin_oe_out <= 1'b0;
      general_io_five_level_out  <= 1'b0;
    end else begin
      general_io_five_pin_out    <= io5_drv_d.o;
      general_io_five_pin_oe_out <= io5_drv_d.oe;
      general_io_five_level_out  <= general_io_five_pin_in;
    end
  end

  // [RULE12] strap selects address set
  always_comb begin
    if (straps.address_and_led_polarity_strap) begin
      addr_d = '{vphy: `PMX_VPHY_ADDR_S1, port1: `PMX_P1_ADDR_S1, port2: `PMX_P2_ADDR_S1};
    end else begin
      addr_d = '{vphy: `PMX_VPHY_ADDR_S0, port1: `PMX_P1_ADDR_S0, port2: `PMX_P2_ADDR_S0};
    end
  end

  // Address outputs move only on capture or override
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      mgmt_addr_out <= '{vphy: `PMX_VPHY_ADDR_S0, port1: `PMX_P1_ADDR_S0, port2: `PMX_P2_ADDR_S0};
    end else begin
      mgmt_addr_out <= addr_d;
    end
  end

  // Read data mux; unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    case (reg_addr_in)
      `PMX_REG_LED_CONFIGURATION: begin
        rdata_d[`PMX_INDICATOR_FIVE_EN_BIT]                  = indicator_five_enable_q;
        rdata_d[`PMX_LED_FUN_MSB:`PMX_LED_FUN_LSB] = led_driver_function_q;
      end
      `PMX_REG_GPIO_CFG: begin
        rdata_d[`PMX_GPIO_OD_BIT] = gpio_open_drain_q;
      end
      `PMX_REG_GPIO_DDR: begin
        rdata_d[`PMX_GPIO_DATA_BIT] = gpio_data_q;
        rdata_d[`PMX_GPIO_DIR_BIT]  = gpio_dir_out_q;
        rdata_d[`PMX_GPIO_PIN_BIT]  = general_io_five_level_out;
      end
      `PMX_REG_VPORT_CTRL: begin
        rdata_d[`PMX_VPORT_AN_BIT] = vport_autoneg_enable_q;
      end
      `PMX_REG_MODE: begin
        rdata_d[`PMX_MODE_MSB:`PMX_MODE_LSB] = p0_mode_q;
        rdata_d[`PMX_MGMT_MASTER_BIT]        = mgmt_master_q;
      end
      `PMX_REG_STRAP_STAT: begin
        rdata_d[`PMX_ST_ADDR_BIT] = straps.address_and_led_polarity_strap;
        rdata_d[`PMX_ST_DPOL_BIT] = straps.port0_duplex_polarity_strap;
        rdata_d[`PMX_ST_DPIN_BIT] = duplex_pin_val;
        rdata_d[`PMX_ST_DEFF_BIT] = port0_duplex_eff_out;
      end
      `PMX_REG_ADDR_STAT: begin
        rdata_d[`PMX_AD_VPHY_LSB +: 5] = mgmt_addr_out.vphy;
        rdata_d[`PMX_AD_P1_LSB +: 5]   = mgmt_addr_out.port1;
        rdata_d[`PMX_AD_P2_LSB +: 5]   = mgmt_addr_out.port2;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // Read data stand one cycle, zero otherwise
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= '0;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= '0;
    end
  end

endmodule : pmx_pin_mux

//--- bench/pmx_pin_mux_assertions.sv
// Port checker for the pin mux, attached to the top module by bind
`timescale 1ns/10ps
module pmx_pin_mux_chk (
  input wire logic                    ref_clk_in,
  input wire logic                    resetn_in,
  input wire logic [7:0]              reg_addr_in,
  input wire logic [31:0]             reg_wdata_in,
  input wire logic                    reg_wr_in,
  input wire logic                    port0_duplex_eff_out,
  input wire logic                    vport_an_duplex_in,
  input wire logic [1:0]              vport_partner_ability_out,
  input wire logic                    mdio_pin_in,
  input wire logic                    mdio_pin_oe_out,
  input wire logic                    mdc_pin_in,
  input wire logic                    mdc_pin_out,
  input wire logic                    mdc_pin_oe_out,
  input wire pmx_pkg::pmx_pin_drv_t   slave_mdio_drv_in,
  input wire logic                    slave_mdio_rx_out,
  input wire logic                    slave_mdc_out,
  input wire pmx_pkg::pmx_pin_drv_t   master_mdio_drv_in,
  input wire logic                    master_mdc_in,
  input wire logic                    master_mdio_rx_out,
  input wire logic                    indicator_five_on_in,
  input wire logic                    general_io_five_pin_in,
  input wire logic                    general_io_five_pin_out,
  input wire logic                    general_io_five_pin_oe_out,
  input wire logic                    general_io_five_level_out,
  input wire pmx_pkg::pmx_mgmt_addr_t mgmt_addr_out
);
  import pmx_pkg::*;
  logic       live_q, mst_q, an_q, en_q, od_q, dat_q, dir_q;
  logic [1:0] mode_q, fun_q;
  // Control-bit shadow; live_q masks the first edge after reset
  always_ff @(posedge ref_clk_in) begin
    live_q <= resetn_in;
    if (!resetn_in) begin
      {mst_q, an_q, en_q, od_q, dat_q, dir_q, mode_q, fun_q} <= '0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        8'h00: {fun_q, en_q} <= {reg_wdata_in[9:8], reg_wdata_in[0]};
        8'h04: od_q <= reg_wdata_in[0];
        8'h08: {dir_q, dat_q} <= {reg_wdata_in[8], reg_wdata_in[0]};
        8'h0c: an_q <= reg_wdata_in[12];
        8'h10: {mst_q, mode_q} <= {reg_wdata_in[4], reg_wdata_in[1:0]};
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  AST_MDC_OE: assert property (live_q |-> mdc_pin_oe_out == $past(mst_q))
    else $error("mdc enable wrong");
  AST_MDC_OUT: assert property (live_q && $past(mst_q) |-> mdc_pin_out == $past(master_mdc_in))
    else $error("mdc pin wrong");
  AST_MDC_IN: assert property (live_q |-> slave_mdc_out == ($past(mst_q) ? 1'b0 : $past(mdc_pin_in)))
    else $error("slave clock wrong");
  AST_MDIO_OE: assert property (live_q |-> mdio_pin_oe_out ==
    ($past(mst_q) ? $past(master_mdio_drv_in.oe) : $past(slave_mdio_drv_in.oe)))
    else $error("mdio enable wrong");
  AST_MDIO_RX: assert property (live_q |-> {slave_mdio_rx_out, master_mdio_rx_out} ==
    ($past(mst_q) ? {1'b1, $past(mdio_pin_in)} : {$past(mdio_pin_in), 1'b1}))
    else $error("mdio receive wrong");
  AST_DUP_AN: assert property (live_q && $past(mode_q) == 2'h0 && $past(an_q) |->
    port0_duplex_eff_out == $past(vport_an_duplex_in)) else $error("autoneg duplex not used");
  AST_ABIL: assert property (live_q && $past(mode_q) inside {2'h1, 2'h2} |->
    vport_partner_ability_out == {port0_duplex_eff_out, !port0_duplex_eff_out}) else $error("ability mismatch");
  AST_LED_PP: assert property (live_q && $past(en_q) && $past(fun_q) == 2'h0 |->
    general_io_five_pin_oe_out && general_io_five_pin_out == $past(indicator_five_on_in))
    else $error("indicator wrong");
  AST_LED_OD: assert property (live_q && $past(en_q) && $past(fun_q) != 2'h0 |->
    general_io_five_pin_oe_out == $past(indicator_five_on_in)) else $error("open indicator wrong");
  AST_GPIO: assert property (live_q && !$past(en_q) |-> general_io_five_pin_oe_out ==
    ($past(dir_q) && !($past(od_q) && $past(dat_q)))) else $error("gpio enable wrong");
  AST_LEVEL: assert property (live_q |-> general_io_five_level_out == $past(general_io_five_pin_in))
    else $error("pin level wrong");
  // Only the two strap address sets
  AST_ADDR: assert property (mgmt_addr_out inside {15'h0022, 15'h0443})
    else $error("addresses illegal");
  COV_MASTER: cover property (mst_q && master_mdc_in);
  COV_LED_OPEN: cover property (en_q && fun_q != 2'h0 && indicator_five_on_in);
  COV_AUTONEG: cover property (an_q && mode_q == 2'h0 && vport_an_duplex_in);
endmodule : pmx_pin_mux_chk

bind pmx_pin_mux pmx_pin_mux_chk i_chk (.*);

//--- bench/pmx_mgmt_partner.sv
// Outside management master or PHY on the management data and clock pins
`timescale 1ns/10ps
module pmx_mgmt_partner (
  input  wire logic clk_in,
  input  wire logic frame_in,
  input  wire logic mdc_o_in,
  input  wire logic mdc_oe_in,
  input  wire logic mdio_o_in,
  input  wire logic mdio_oe_in,
  output logic      mdc_out,
  output logic      mdio_out
);
  logic clk_q = 1'b0;
  logic pat_q = 1'b0;
  // clock runs only in frames, low between
  always_ff @(posedge clk_in) begin
    clk_q <= (frame_in && !mdc_oe_in) ? !clk_q : 1'b0;
    pat_q <= !pat_q;
  end
  // device wins, else pattern, else pulls
  assign mdc_out  = mdc_oe_in ? mdc_o_in : clk_q;
  assign mdio_out = mdio_oe_in ? mdio_o_in : (frame_in ? pat_q : 1'b1);
endmodule : pmx_mgmt_partner

//--- bench/pmx_pin_mux_test.sv
// Self-checking testbench for the pin mux
`timescale 1ns/10ps
module pmx_pin_mux_test;
  import pmx_pkg::*;
  logic ref_clk_in, resetn_in, external_reset_n_in, reg_wr_in, reg_rd_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  pmx_straps_t strap_pins_in;
  pmx_strap_ovr_t eeprom_ovr_in;
  logic port0_duplex_in, vport_an_duplex_in, port0_duplex_eff_out;
  logic [1:0] vport_partner_ability_out;
  logic mdio_pin_in, mdio_pin_out, mdio_pin_oe_out, mdc_pin_in, mdc_pin_out, mdc_pin_oe_out;
  pmx_pin_drv_t slave_mdio_drv_in, master_mdio_drv_in;
  logic slave_mdio_rx_out, slave_mdc_out, master_mdc_in, master_mdio_rx_out, indicator_five_on_in;
  logic general_io_five_pin_in, general_io_five_pin_out, general_io_five_pin_oe_out, general_io_five_level_out;
  pmx_mgmt_addr_t mgmt_addr_out;
  logic frame, gp_drv, gp_val;
  int n_mismatch, total_checks;

  pmx_pin_mux i_dut (.*);
  pmx_mgmt_partner i_part (.clk_in(ref_clk_in), .frame_in(frame), .mdc_o_in(mdc_pin_out),
    .mdc_oe_in(mdc_pin_oe_out), .mdio_o_in(mdio_pin_out), .mdio_oe_in(mdio_pin_oe_out),
    .mdc_out(mdc_pin_in), .mdio_out(mdio_pin_in));
  // Shared pin: device, else bench, else pull-up
  assign general_io_five_pin_in = general_io_five_pin_oe_out ? general_io_five_pin_out : (gp_drv ? gp_val : 1'b1);

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  // Read data stand one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge ref_clk_in);
    chk(name, reg_rdata_out, exp);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask : settle

  task automatic ovr(input logic [4:0] v);
    @(posedge ref_clk_in);
    eeprom_ovr_in <= v;
    @(posedge ref_clk_in);
    eeprom_ovr_in <= '0;
    settle(3);
  endtask : ovr

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // Watchdog, far beyond the test length
  initial begin
    #100000;
    n_mismatch++;
    results();
  end

  initial begin
    {resetn_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, eeprom_ovr_in} = '0;
    {port0_duplex_in, vport_an_duplex_in, master_mdc_in, indicator_five_on_in} = '0;
    {slave_mdio_drv_in, master_mdio_drv_in, frame, gp_drv, gp_val} = '0;
    external_reset_n_in = 1'b1;
    strap_pins_in = 2'b11;
    n_mismatch = 0;
    total_checks = 0;
    repeat (16) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    settle(4);
    // Straps 11 at release; pin 0 inverted
    chk("addresses", {17'h0, mgmt_addr_out}, 32'h0443);
    rd(8'h14, 32'h0303, "strap status");
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, 32'h0303, "held straps");
    @(posedge ref_clk_in);
    external_reset_n_in <= 1'b0;
    strap_pins_in <= 2'b00;
    @(posedge ref_clk_in);
    external_reset_n_in <= 1'b1;
    settle(4);
    rd(8'h14, 32'h0000, "recaptured straps");
    chk("addresses", {17'h0, mgmt_addr_out}, 32'h0022);
    ovr(5'h15);
    chk("override address", {17'h0, mgmt_addr_out}, 32'h0443);
    // MAC mode: autoneg else live pin
    for (int i = 0; i < 4; i++) begin
      wr(8'h0c, {19'h0, i[1], 12'h0});
      @(posedge ref_clk_in);
      vport_an_duplex_in <= i[0];
      port0_duplex_in <= !i[0];
      settle(2);
      chk("duplex", {31'h0, port0_duplex_eff_out}, {31'h0, i[1] ? i[0] : !i[0]});
    end
    for (int m = 1; m < 3; m++) begin
      wr(8'h10, 32'(m));
      for (int p = 0; p < 2; p++) begin
        @(posedge ref_clk_in);
        port0_duplex_in <= p[0];
        settle(2);
        chk("ability", {30'h0, vport_partner_ability_out}, p[0] ? 32'h2 : 32'h1);
      end
    end
    ovr(5'h1a);
    chk("inverted ability", {30'h0, vport_partner_ability_out}, 32'h1);
    // Slave then master management
    @(posedge ref_clk_in);
    frame <= 1'b1;
    for (int ms = 0; ms < 2; ms++) begin
      wr(8'h10, {27'h0, ms[0], 4'h0});
      for (int k = 0; k < 4; k++) begin
        @(posedge ref_clk_in);
        master_mdc_in <= k[0];
        slave_mdio_drv_in <= {k[0], k[1]};
        master_mdio_drv_in <= {k[1], k[0]};
        settle(2);
        chk("mdc enable", {31'h0, mdc_pin_oe_out}, {31'h0, ms[0]});
        chk("mdio enable", {31'h0, mdio_pin_oe_out}, {31'h0, ms[0] ? k[0] : k[1]});
        chk("mdio out", {31'h0, mdio_pin_out}, {31'h0, ms[0] ? k[1] : k[0]});
        if (ms == 1) chk("mdc out", {31'h0, mdc_pin_out}, {31'h0, k[0]});
      end
    end
    // All driver codes; open output active low
    for (int f = 0; f < 4; f++) begin
      wr(8'h00, {22'h0, f[1:0], 8'h01});
      for (int on = 0; on < 2; on++) begin
        @(posedge ref_clk_in);
        indicator_five_on_in <= on[0];
        settle(2);
        chk("led", {30'h0, general_io_five_pin_oe_out, general_io_five_pin_out},
          f == 0 ? {30'h0, 1'b1, on[0]} : {30'h0, on[0], 1'b0});
      end
    end
    ovr(5'h14);
    chk("led active high", {30'h0, general_io_five_pin_oe_out, general_io_five_pin_out}, 32'h3);
    wr(8'h00, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(8'h04, {31'h0, c[2]});
      wr(8'h08, {23'h0, c[1], 7'h0, c[0]});
      settle(2);
      chk("gpio enable", {31'h0, general_io_five_pin_oe_out}, {31'h0, c[1] && !(c[2] && c[0])});
      if (c[1] && !c[2]) chk("gpio out", {31'h0, general_io_five_pin_out}, {31'h0, c[0]});
    end
    @(posedge ref_clk_in);
    gp_drv <= 1'b1;
    settle(3);
    rd(8'h08, 32'h0000_0101, "gpio input low");
    @(posedge ref_clk_in);
    gp_val <= 1'b1;
    settle(3);
    rd(8'h08, 32'h0001_0101, "gpio input high");
    rd(8'h40, 32'h0, "unmapped");
    results();
  end
endmodule : pmx_pin_mux_test
